// [logic/core_consts.vh]
// constants, field layouts and codes shared by the core front end
// Summary of operation
// - instructions are one 32-bit word, two when format B takes a displacement, fetched only from word-aligned addresses
// - decoder knows five encodings; format codes 5 to 7 are flagged illegal
// - only loads and stores reach memory; all else is register to register
// - issue continues past a load; its target stays busy until data lands
// - a pending compare is scoreboarded; unrelated instructions keep issuing
// - alu result goes to its register and bypasses to the next operand
// - fetch uses four-word bursts written straight into the cache line
// - on a miss the arriving word feeds decode while the line fills
// - moves, add/subtract, logic and shifts finish within one or two cycles
// - addresses are 32 bits in one flat 4 gigabyte space
// - modes: absolute 12/32-bit, register indirect, register plus 12/32-bit
// - indexed modes scale the index by 1, 2, 4, 8 or 16
// - thirty-two 32-bit registers plus four 80-bit floating registers
// - 8/16/32/64-bit signed and unsigned data, 32/64/80-bit reals
// - at most three loads outstanding, each with its own busy bit
// - cache fills move 16-byte blocks of up to four instructions
`ifndef CORE_CONSTS_VH
`define CORE_CONSTS_VH
// ==========================================================
// instruction formats, bits 31:29
`define FMT_CTRL 3'h0
`define FMT_COBR 3'h1
`define FMT_REG 3'h2
`define FMT_MEMA 3'h3
`define FMT_MEMB 3'h4
// ==========================================================
// alu operations, bits 27:24 of the register format
`define OP_MOV 4'h0
`define OP_ADD 4'h1
`define OP_SUB 4'h2
`define OP_AND 4'h3
`define OP_OR 4'h4
`define OP_XOR 4'h5
`define OP_NOT 4'h6
`define OP_SHL 4'h7
`define OP_SHR 4'h8
`define OP_SRA 4'h9
`define OP_CMP 4'ha
`define OP_TOFP 4'hd
`define OP_FROMFP 4'he
// ==========================================================
// memory access sizes, bits 27:25 of the memory formats
`define SZ_BYTE 3'h0
`define SZ_HALF 3'h1
`define SZ_WORD 3'h2
`define SZ_LONG 3'h3
`define SZ_EXT 3'h4
// ==========================================================
// addressing modes
`define AM_ABS12 3'h0
`define AM_ABS32 3'h1
`define AM_RIND 3'h2
`define AM_ROFF12 3'h3
`define AM_ROFF32 3'h4
`define AM_RX 3'h5
`define AM_XDISP 3'h6
`define AM_RXDISP 3'h7
`define SCALE_MAX 3'h4
// ==========================================================
// fetch, cache and scoreboard figures
`define BEAT_LAST 2'h3
`define MAX_LOADS 2'h3
`define LQ_LAST 2'h2
`define RESET_PC 32'h0000_0000
`define PC_STEP 32'h0000_0004
`endif

// [logic/alu_unit.v]
// single-cycle integer alu with compare flags
`timescale 1ns/1ps
`include "core_consts.vh"
module alu_unit (
  input wire [3:0] op,
  input wire [31:0] opA,
  input wire [31:0] opB,
  output reg [31:0] result,
  output wire [2:0] ccOut
);
  // ==========================================================
  // operations
  // purely combinational so the result is ready for same-cycle bypass
  always @* begin
    case (op)
      `OP_MOV: result = opA;
      `OP_ADD: result = opA + opB;
      `OP_SUB: result = opA - opB;
      `OP_AND: result = opA & opB;
      `OP_OR: result = opA | opB;
      `OP_XOR: result = opA ^ opB;
      `OP_NOT: result = ~opA;
      `OP_SHL: result = opA << opB[4:0];
      `OP_SHR: result = opA >> opB[4:0];
      `OP_SRA: result = $signed(opA) >>> opB[4:0];
      default: result = opA;
    endcase
  end
  // ==========================================================
  // flags: less, equal, greater, signed view
  assign ccOut = {$signed(opA) < $signed(opB), opA == opB, $signed(opA) > $signed(opB)};
endmodule // alu_unit

// [logic/addr_gen.v]
// effective address generation for loads and stores
`timescale 1ns/1ps
`include "core_consts.vh"
module addr_gen (
  input wire [2:0] mode,
  input wire [31:0] base,
  input wire [31:0] index,
  input wire [2:0] scale,
  input wire [11:0] off12,
  input wire [31:0] disp,
  output reg [31:0] effAddr
);
  // ==========================================================
  // scaled index; codes above four are rejected by the decoder
  wire [31:0] scaled = index << scale;
  wire [31:0] offExt = {20'h0, off12};
  // ==========================================================
  // mode select, plain 32-bit wraparound arithmetic
  always @* begin
    case (mode)
      `AM_ABS12: effAddr = offExt;
      `AM_ABS32: effAddr = disp;
      `AM_RIND: effAddr = base;
      `AM_ROFF12: effAddr = base + offExt;
      `AM_ROFF32: effAddr = base + disp;
      `AM_RX: effAddr = base + scaled;
      `AM_XDISP: effAddr = scaled + disp;
      `AM_RXDISP: effAddr = base + scaled + disp;
      default: effAddr = base;
    endcase
  end
endmodule // addr_gen

// [logic/core_front.v]
// fetch, decode, scoreboard and execute front end of the core
`timescale 1ns/1ps
`include "core_consts.vh"
module core_front (
  input wire core_clk,
  input wire rst_n,
  output wire fetchReq,
  output wire [31:0] fetchAddr,
  input wire [31:0] fetchData,
  input wire fetchValid,
  output wire memReq,
  output wire memWrite,
  output wire [31:0] memAddr,
  output wire [79:0] memWdata,
  output wire [2:0] memSize,
  input wire memAck,
  input wire loadValid,
  input wire [79:0] loadData,
  output wire illegalInstr
);
  // ==========================================================
  // state
  reg [31:0] pc_r;
  reg [31:0] icData_r [0:127];
  reg [22:0] icTag_r [0:31];
  reg [31:0] icValid_r;
  reg filling_r;
  reg [1:0] beat_r;
  reg [31:0] fillBase_r;
  reg fetchReq_r;
  reg dispWait_r;
  reg [31:0] held_r;
  reg [31:0] regs_r [0:31];
  reg [79:0] fpRegs_r [0:3];
  reg [31:0] regBusy_r;
  reg [31:0] regBusy_nxt;
  reg [3:0] fpBusy_r;
  reg [3:0] fpBusy_nxt;
  reg ccBusy_r;
  reg [2:0] cc_r;
  reg [4:0] lqDst_r [0:2];
  reg [2:0] lqSize_r [0:2];
  reg [2:0] lqSgn_r;
  reg [1:0] lqHead_r;
  reg [1:0] lqTail_r;
  reg [1:0] lqCount_r;
  reg memReq_r;
  reg memWrite_r;
  reg [31:0] memAddr_r;
  reg [79:0] memWdata_r;
  reg [2:0] memSize_r;
  reg illegal_r;
  reg exeValid_r;
  reg exeWr_r;
  reg exeToFp_r;
  reg exeCmp_r;
  reg [3:0] exeOp_r;
  reg [4:0] exeDst_r;
  reg [31:0] exeA_r;
  reg [31:0] exeB_r;
  reg [31:0] ldVal;
  wire [31:0] aluRes;
  wire [2:0] aluCc;
  wire [31:0] effAddr;
  integer i;
  integer j;

  // ==========================================================
  // fetch: cache lookup, or the burst word itself while filling
  wire [4:0] pcLine = pc_r[8:4];
  wire cacheHit = icValid_r[pcLine] && (icTag_r[pcLine] == pc_r[31:9]) && !filling_r;
  wire fillBypass = filling_r && fetchValid && (fillBase_r[31:4] == pc_r[31:4])
    && (beat_r == pc_r[3:2]);
  wire fValid = cacheHit || fillBypass;
  wire [31:0] fWord = cacheHit ? icData_r[{pcLine, pc_r[3:2]}] : fetchData;

  // ==========================================================
  // decode
  wire [31:0] cur = dispWait_r ? held_r : fWord;
  wire [2:0] fmt = cur[31:29];
  wire isCtrl = fmt == `FMT_CTRL;
  wire isCobr = fmt == `FMT_COBR;
  wire isReg = fmt == `FMT_REG;
  wire isMem = (fmt == `FMT_MEMA) || (fmt == `FMT_MEMB);
  wire legalFmt = fmt <= `FMT_MEMB;
  wire [3:0] op = cur[27:24];
  wire [4:0] rd = cur[23:19];
  wire [4:0] rs1 = cur[18:14];
  wire [4:0] rs2 = cur[4:0];
  wire [4:0] rdE = {rd[4:1], 1'b0};
  wire [4:0] rdO = {rd[4:1], 1'b1};
  wire isStore = isMem && cur[28];
  wire isLoad = isMem && !cur[28];
  wire [2:0] size = cur[27:25];
  wire isLong = size == `SZ_LONG;
  wire isExt = size == `SZ_EXT;
  wire [2:0] mode = (fmt == `FMT_MEMA) ? (cur[13] ? `AM_ROFF12 : `AM_ABS12) : cur[13:11];
  wire [2:0] scale = cur[10:8];
  wire needDisp = (fmt == `FMT_MEMB) && ((mode == `AM_ABS32) || (mode == `AM_ROFF32)
    || (mode == `AM_XDISP) || (mode == `AM_RXDISP));
  wire useBase = isMem && ((mode == `AM_RIND) || (mode == `AM_ROFF12)
    || (mode == `AM_ROFF32) || (mode == `AM_RX) || (mode == `AM_RXDISP));
  wire useIdx = isMem && ((mode == `AM_RX) || (mode == `AM_XDISP) || (mode == `AM_RXDISP));
  wire badScale = useIdx && (scale > `SCALE_MAX);
  wire illegalNow = !dispWait_r && (!legalFmt || badScale);
  wire regImm = isReg && cur[13];
  wire regToFp = isReg && (op == `OP_TOFP);
  wire regFromFp = isReg && (op == `OP_FROMFP);
  wire regCmp = isReg && (op == `OP_CMP);
  wire oneOp = (op == `OP_MOV) || (op == `OP_NOT) || regToFp || regFromFp;

  // ==========================================================
  // hazards; the scoreboard stalls only instructions that touch busy state
  wire readA = isCobr || useBase || (isReg && !regFromFp);
  wire readB = isCobr || useIdx || (isReg && !regImm && !oneOp);
  wire readSt = isStore && !isExt;
  wire readSt2 = isStore && isLong;
  wire [4:0] stSrc = isLong ? rdE : rd;
  wire writeD = (isReg && !regCmp && !regToFp) || (isLoad && !isExt);
  wire writeD2 = isLoad && isLong;
  wire [4:0] wrD = (isLoad && isLong) ? rdE : rd;
  wire [1:0] fpIdx = regFromFp ? rs1[1:0] : rd[1:0];
  wire fpHit = (regToFp || regFromFp || (isMem && isExt)) && fpBusy_r[fpIdx];
  wire busyHit = (readA && regBusy_r[rs1]) || (readB && regBusy_r[rs2])
    || (readSt && regBusy_r[stSrc]) || (readSt2 && regBusy_r[rdO])
    || (writeD && regBusy_r[wrD]) || (writeD2 && regBusy_r[rdO]) || fpHit;
  wire ccWait = isCtrl && cur[28] && ccBusy_r;
  wire memWait = isMem && memReq_r && !memAck;
  // conservative: a return in the same cycle does not free a slot early
  wire lqFull = isLoad && (lqCount_r == `MAX_LOADS);
  wire stall = busyHit || ccWait || memWait || lqFull;
  wire capture = !dispWait_r && needDisp && !illegalNow;
  wire take = fValid && (capture || illegalNow || !stall);
  wire issue = fValid && !capture && !illegalNow && !stall;

  // ==========================================================
  // operand read with alu bypass
  // plain muxes, not a function: a stalled reader must see the file change under it
  wire exeFwd = exeValid_r && exeWr_r;
  wire [31:0] opA = (exeFwd && (exeDst_r == rs1)) ? aluRes : regs_r[rs1];
  wire [31:0] opBReg = (exeFwd && (exeDst_r == rs2)) ? aluRes : regs_r[rs2];
  wire [31:0] opB = regImm ? {27'h0, rs2} : opBReg;
  wire [31:0] stLo = (exeFwd && (exeDst_r == stSrc)) ? aluRes : regs_r[stSrc];
  wire [31:0] stHi = (exeFwd && (exeDst_r == rdO)) ? aluRes : regs_r[rdO];
  wire brTaken = !cur[28] || (|(cc_r & cur[27:25]));
  wire [31:0] brTarget = pc_r + {{6{cur[23]}}, cur[23:0], 2'b00};
  wire [31:0] pcStep = pc_r + `PC_STEP;

  alu_unit u_alu (
    .op(exeOp_r),
    .opA(exeA_r),
    .opB(exeB_r),
    .result(aluRes),
    .ccOut(aluCc)
  );

  addr_gen u_addr (
    .mode(mode),
    .base(opA),
    .index(opBReg),
    .scale(scale),
    .off12(cur[11:0]),
    .disp(fWord),
    .effAddr(effAddr)
  );

  // ==========================================================
  // program counter, burst fill control
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_r <= `RESET_PC;
      filling_r <= 1'b0;
      beat_r <= 2'h0;
      fillBase_r <= 32'h0;
      fetchReq_r <= 1'b0;
      icValid_r <= 32'h0;
      dispWait_r <= 1'b0;
      held_r <= 32'h0;
      illegal_r <= 1'b0;
    end else begin
      illegal_r <= take && illegalNow;
      if (take) begin
        if (capture) begin
          held_r <= fWord;
          dispWait_r <= 1'b1;
          pc_r <= pcStep;
        end else begin
          dispWait_r <= 1'b0;
          pc_r <= (issue && isCtrl && brTaken) ? brTarget : pcStep;
        end
      end
      if (!filling_r && !cacheHit) begin
        filling_r <= 1'b1;
        fillBase_r <= {pc_r[31:4], 4'h0};
        fetchReq_r <= 1'b1;
        beat_r <= 2'h0;
        icValid_r[pcLine] <= 1'b0;
      end else if (filling_r && fetchValid) begin
        beat_r <= beat_r + 2'h1;
        if (beat_r == `BEAT_LAST) begin
          filling_r <= 1'b0;
          fetchReq_r <= 1'b0;
          icValid_r[fillBase_r[8:4]] <= 1'b1;
        end
      end
    end
  end

  // line storage; valid bits guard it, so no reset is needed here
  always @(posedge core_clk) begin
    if (!filling_r && !cacheHit) begin
      icTag_r[pcLine] <= pc_r[31:9];
    end
    if (filling_r && fetchValid) begin
      icData_r[{fillBase_r[8:4], beat_r}] <= fetchData;
    end
  end

  // ==========================================================
  // execute stage and condition code
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      exeValid_r <= 1'b0;
      exeWr_r <= 1'b0;
      exeToFp_r <= 1'b0;
      exeCmp_r <= 1'b0;
      exeOp_r <= `OP_MOV;
      exeDst_r <= 5'h0;
      exeA_r <= 32'h0;
      exeB_r <= 32'h0;
      ccBusy_r <= 1'b0;
      cc_r <= 3'h0;
    end else begin
      exeValid_r <= issue && (isReg || isCobr);
      exeOp_r <= (isCobr ? `OP_CMP : (regFromFp ? `OP_MOV : op));
      exeA_r <= regFromFp ? fpRegs_r[rs1[1:0]][31:0] : opA;
      exeB_r <= opB;
      exeDst_r <= rd;
      exeWr_r <= isReg && writeD;
      exeToFp_r <= regToFp;
      exeCmp_r <= isCobr || regCmp;
      if (issue && (isCobr || regCmp)) begin
        ccBusy_r <= 1'b1;
      end else if (exeValid_r && exeCmp_r) begin
        ccBusy_r <= 1'b0;
      end
      if (exeValid_r && exeCmp_r) begin
        cc_r <= aluCc;
      end
    end
  end

  // ==========================================================
  // load return and scoreboard; set after clear so a set is never lost
  wire ldActive = loadValid && (lqCount_r != 2'h0);
  wire [4:0] lqD = lqDst_r[lqHead_r];
  wire [2:0] lqS = lqSize_r[lqHead_r];
  wire lqG = lqSgn_r[lqHead_r];
  always @* begin
    case (lqS)
      `SZ_BYTE: ldVal = lqG ? {{24{loadData[7]}}, loadData[7:0]} : {24'h0, loadData[7:0]};
      `SZ_HALF: ldVal = lqG ? {{16{loadData[15]}}, loadData[15:0]} : {16'h0, loadData[15:0]};
      default: ldVal = loadData[31:0];
    endcase
    regBusy_nxt = regBusy_r;
    fpBusy_nxt = fpBusy_r;
    if (ldActive && (lqS == `SZ_EXT)) begin
      fpBusy_nxt[lqD[1:0]] = 1'b0;
    end else if (ldActive) begin
      regBusy_nxt[(lqS == `SZ_LONG) ? {lqD[4:1], 1'b0} : lqD] = 1'b0;
      regBusy_nxt[{lqD[4:1], 1'b1}] = regBusy_nxt[{lqD[4:1], 1'b1}] && (lqS != `SZ_LONG);
    end
    if (exeValid_r && exeToFp_r) begin
      fpBusy_nxt[exeDst_r[1:0]] = 1'b0;
    end
    if (issue && isLoad && !isExt) begin
      regBusy_nxt[wrD] = 1'b1;
      regBusy_nxt[rdO] = regBusy_nxt[rdO] || writeD2;
    end
    if (issue && (regToFp || (isLoad && isExt))) begin
      fpBusy_nxt[rd[1:0]] = 1'b1;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regBusy_r <= 32'h0;
      fpBusy_r <= 4'h0;
      lqHead_r <= 2'h0;
      lqTail_r <= 2'h0;
      lqCount_r <= 2'h0;
      lqSgn_r <= 3'h0;
      for (i = 0; i < 3; i = i + 1) begin
        lqDst_r[i] <= 5'h0;
        lqSize_r[i] <= `SZ_WORD;
      end
    end else begin
      regBusy_r <= regBusy_nxt;
      fpBusy_r <= fpBusy_nxt;
      if (issue && isLoad) begin
        lqDst_r[lqTail_r] <= rd;
        lqSize_r[lqTail_r] <= size;
        lqSgn_r[lqTail_r] <= cur[24];
        lqTail_r <= (lqTail_r == `LQ_LAST) ? 2'h0 : lqTail_r + 2'h1;
      end
      if (ldActive) begin
        lqHead_r <= (lqHead_r == `LQ_LAST) ? 2'h0 : lqHead_r + 2'h1;
      end
      lqCount_r <= lqCount_r + {1'b0, issue && isLoad} - {1'b0, ldActive};
    end
  end

  // ==========================================================
  // register files; alu and load writes never share a target
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (j = 0; j < 32; j = j + 1) begin
        regs_r[j] <= 32'h0;
      end
      for (j = 0; j < 4; j = j + 1) begin
        fpRegs_r[j] <= 80'h0;
      end
    end else begin
      if (exeValid_r && exeWr_r) begin
        regs_r[exeDst_r] <= aluRes;
      end
      if (ldActive && (lqS != `SZ_EXT)) begin
        regs_r[(lqS == `SZ_LONG) ? {lqD[4:1], 1'b0} : lqD] <= ldVal;
      end
      if (ldActive && (lqS == `SZ_LONG)) begin
        regs_r[{lqD[4:1], 1'b1}] <= loadData[63:32];
      end
      if (ldActive && (lqS == `SZ_EXT)) begin
        fpRegs_r[lqD[1:0]] <= loadData;
      end
      if (exeValid_r && exeToFp_r) begin
        fpRegs_r[exeDst_r[1:0]] <= {48'h0, exeA_r};
      end
    end
  end

  // ==========================================================
  // data memory request, loads and stores only
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      memReq_r <= 1'b0;
      memWrite_r <= 1'b0;
      memAddr_r <= 32'h0;
      memWdata_r <= 80'h0;
      memSize_r <= `SZ_WORD;
    end else if (issue && isMem) begin
      memReq_r <= 1'b1;
      memWrite_r <= isStore;
      memAddr_r <= effAddr;
      memSize_r <= size;
      if (isExt) begin
        memWdata_r <= fpRegs_r[rd[1:0]];
      end else if (isLong) begin
        memWdata_r <= {16'h0, stHi, stLo};
      end else begin
        memWdata_r <= {48'h0, stLo};
      end
    end else if (memAck) begin
      memReq_r <= 1'b0;
    end
  end

  // ==========================================================
  // outputs
  assign fetchReq = fetchReq_r;
  assign fetchAddr = fillBase_r;
  assign memReq = memReq_r;
  assign memWrite = memWrite_r;
  assign memAddr = memAddr_r;
  assign memWdata = memWdata_r;
  assign memSize = memSize_r;
  assign illegalInstr = illegal_r;
endmodule // core_front

// [testbench/core_front_sva.sv]
// port assertions for the core front end
`timescale 1ns/1ps
module core_front_sva (
  input wire core_clk,
  input wire rst_n,
  input wire fetchReq,
  input wire [31:0] fetchAddr,
  input wire fetchValid,
  input wire memReq,
  input wire memWrite,
  input wire [31:0] memAddr,
  input wire [2:0] memSize,
  input wire memAck,
  input wire loadValid
);
  // ======
  // helper state
  logic [1:0] beatCnt_r;
  logic [2:0] pendCnt_r;
  logic fresh_r;
  wire ldTake = memReq && memAck && !memWrite;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      beatCnt_r <= 2'h0;
      pendCnt_r <= 3'h0;
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
      if (!fetchReq) beatCnt_r <= 2'h0;
      else if (fetchValid) beatCnt_r <= beatCnt_r + 2'h1;
      // returns come in order, so a plain count is enough
      pendCnt_r <= pendCnt_r + {2'h0, ldTake} - {2'h0, loadValid && pendCnt_r != 3'h0};
    end
  end
  // ======
  // properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  fetch_align_a: assert property (fetchReq |-> fetchAddr[3:0] == 4'h0)
    else $error("fetch address not line aligned");
  fetch_hold_a: assert property (
    fetchReq && !(fetchValid && beatCnt_r == 2'h3) |=> fetchReq && $stable(fetchAddr))
    else $error("burst dropped before four beats");
  burst_end_a: assert property (
    fetchReq && fetchValid && beatCnt_r == 2'h3 |=> !fetchReq)
    else $error("burst ran past four beats");
  req_hold_a: assert property (memReq && !memAck |=> memReq && $stable(memAddr)
    && $stable(memSize) && $stable(memWrite))
    else $error("data request changed before ack");
  req_drop_a: assert property ($fell(memReq) |-> $past(memAck))
    else $error("data request withdrawn without ack");
  load_limit_a: assert property (ldTake |-> pendCnt_r < 3'h3)
    else $error("fourth load issued");
  size_legal_a: assert property (memReq |-> memSize <= 3'h4)
    else $error("unknown access size");
  reset_fetch_a: assert property (fresh_r |=> fetchReq && fetchAddr == 32'h0)
    else $error("no fetch of address zero after reset");
  cover property (ldTake);
  cover property (memReq && memAck && memWrite);
  cover property (fetchReq && fetchValid && beatCnt_r == 2'h3);
endmodule // core_front_sva

// [testbench/mem_model.sv]
// behavioural memory side of the burst bus
`timescale 1ns/1ps
module mem_model (
  input wire core_clk,
  input wire fetchReq,
  input wire [31:0] fetchAddr,
  output logic [31:0] fetchData,
  output logic fetchValid,
  input wire memReq,
  input wire memWrite,
  input wire [31:0] memAddr,
  output logic memAck,
  output logic loadValid,
  output logic [79:0] loadData,
  input wire loadHold
);
  // ======
  // state
  logic [31:0] rom [0:15];
  logic [31:0] ldQ [$];
  int beat = 0;
  int dly = 0;
  initial begin
    fetchData = 32'h0;
    fetchValid = 1'b0;
    memAck = 1'b0;
    loadValid = 1'b0;
    loadData = 80'h0;
  end
  // ======
  // responses
  always @(negedge core_clk) begin
    if (!fetchReq) beat = 0;
    // a gap between beats: the core must not assume a dense burst
    if (fetchReq && beat < 4 && !fetchValid) begin
      fetchData = rom[fetchAddr[5:2] + beat[3:0]];
      fetchValid = 1'b1;
      beat++;
    end else begin
      fetchValid = 1'b0;
      fetchData = ~fetchData;
    end
    loadValid = 1'b0;
    loadData = ~loadData;
    // returns before acks, so no load comes back ahead of its own ack
    if (ldQ.size() > 0 && !loadHold && dly >= 16) begin
      loadValid = 1'b1;
      loadData = {48'h0, ldQ.pop_front()};
      dly = 0;
    end else dly++;
    if (memReq && !memAck) begin
      memAck = 1'b1;
      if (!memWrite) ldQ.push_back(~memAddr);
      if (!memWrite) dly = 0;
    end else memAck = 1'b0;
  end
endmodule // mem_model

// [testbench/risc_core_decode_execute_tb_top.sv]
// testbench top for the core front end
`timescale 1ns/1ps
module risc_core_decode_execute_tb_top;
  // ======
  // clock, reset and wiring
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic loadHold = 1'b0;
  wire fetchReq, fetchValid, memReq, memWrite, memAck, loadValid, illegalInstr;
  wire [31:0] fetchAddr, fetchData, memAddr;
  wire [79:0] memWdata, loadData;
  wire [2:0] memSize;
  int num_errors = 0;
  int n_checks = 0;
  int illegals = 0;
  int returns = 0;
  logic [75:0] reqLog [$];
  always #2.5 core_clk = ~core_clk;
  core_front uut (.core_clk(core_clk), .rst_n(rst_n), .fetchReq(fetchReq),
    .fetchAddr(fetchAddr), .fetchData(fetchData), .fetchValid(fetchValid), .memReq(memReq),
    .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata), .memSize(memSize),
    .memAck(memAck), .loadValid(loadValid), .loadData(loadData), .illegalInstr(illegalInstr));
  mem_model mem (.core_clk(core_clk), .fetchReq(fetchReq), .fetchAddr(fetchAddr),
    .fetchData(fetchData), .fetchValid(fetchValid), .memReq(memReq), .memWrite(memWrite),
    .memAddr(memAddr), .memAck(memAck), .loadValid(loadValid), .loadData(loadData),
    .loadHold(loadHold));
  // log of taken requests with the load returns seen so far
  always @(posedge core_clk) begin
    if (memReq && memAck)
      reqLog.push_back({returns[7:0], memWrite, memSize, memAddr, memWdata[31:0]});
    if (illegalInstr) illegals++;
    if (loadValid) returns++;
  end
  // ======
  // shared tasks
  task automatic check(input string what, input logic [75:0] seen, input logic [75:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk_req(input int i, input logic [35:0] kind, input logic [31:0] d,
    input logic [31:0] m);
    logic [75:0] e;
    e = reqLog[i];
    check("request kind and address", e[67:32], kind);
    check("request data", e[31:0] & m, d & m);
  endtask
  task automatic start(input logic [31:0] p [16], input logic hold);
    @(negedge core_clk);
    rst_n = 1'b0;
    loadHold = hold;
    foreach (p[i]) mem.rom[i] = p[i];
    repeat (5) @(negedge core_clk);
    reqLog.delete();
    illegals = 0;
    returns = 0;
    rst_n = 1'b1;
  endtask
  task automatic wait_reqs(input int n);
    int t;
    t = 0;
    while (reqLog.size() < n && t < 2000) begin
      @(negedge core_clk);
      t++;
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ======
  // scenarios
  task automatic test_pipeline();
    start('{32'h64080100, 32'h41102005, 32'h4118a003, 32'h74180200, 32'h7018a010,
      32'h74080204, 32'h20008003, 32'h1a000002, 32'h74100208, 32'ha0000000, 32'h9418ea02,
      32'h94100800, 32'hfffffff0, 32'h0, 32'h0, 32'h0}, 1'b0);
    wait_reqs(6);
    repeat (60) @(negedge core_clk);
    check("requests", reqLog.size(), 6);
    chk_req(0, {1'b0, 3'h2, 32'h100}, 32'h0, 32'h0);
    chk_req(1, {1'b1, 3'h2, 32'h200}, 32'h8, 32'hffffffff);
    check("store ahead of load data", reqLog[1][75:68], 8'h0);
    chk_req(2, {1'b1, 3'h0, 32'h15}, 32'h8, 32'hff);
    chk_req(3, {1'b1, 3'h2, 32'h204}, 32'hfffffeff, 32'hffffffff);
    chk_req(4, {1'b1, 3'h2, 32'h1c}, 32'h8, 32'hffffffff);
    chk_req(5, {1'b1, 3'h2, 32'hfffffff0}, 32'h5, 32'hffffffff);
    check("illegal words", illegals, 1);
  endtask
  task automatic test_loads();
    start('{32'h64200110, 32'h64280114, 32'h64300118, 32'h6438011c, 32'h74380300,
      32'h41402007, 32'h414a2001, 32'h74480304, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
      32'h0, 32'h0, 32'h0}, 1'b1);
    wait_reqs(3);
    repeat (60) @(negedge core_clk);
    check("loads in flight", reqLog.size(), 3);
    loadHold = 1'b0;
    wait_reqs(6);
    chk_req(3, {1'b0, 3'h2, 32'h11c}, 32'h0, 32'h0);
    chk_req(4, {1'b1, 3'h2, 32'h300}, 32'hfffffee3, 32'hffffffff);
    chk_req(5, {1'b1, 3'h2, 32'h304}, 32'h8, 32'hffffffff);
  endtask
  initial begin
    test_pipeline();
    test_loads();
    finish_test();
  end
  // both scenarios need well under 5000 cycles; 20000 leaves ample margin
  initial begin
    #100000;
    num_errors++;
    finish_test();
  end
endmodule // risc_core_decode_execute_tb_top
bind core_front core_front_sva chk (.core_clk(core_clk), .rst_n(rst_n), .fetchReq(fetchReq),
  .fetchAddr(fetchAddr), .fetchValid(fetchValid), .memReq(memReq), .memWrite(memWrite),
  .memAddr(memAddr), .memSize(memSize), .memAck(memAck), .loadValid(loadValid));
